//--- pkg/rlp_pkg.sv
// Shared constants and types for the reset, link and polarity block
package rlp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NPORT = 4;
    localparam int AW = 8;
    localparam int DW = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_IN_PS_DIV1000 = 1000000;
    localparam int MS_CYCLES_NOM = MS_IN_PS_DIV1000 * 1000 / CLK_PERIOD_PS;
    localparam int LP_IDLE_MIN_MS = 8;
    localparam int LP_IDLE_MAX_MS = 17;
    localparam int LF_LOSS_MIN_MS = 65;
    localparam int LF_LOSS_MAX_MS = 132;
    // Tick counts land inside the windows for one tick of slop
    localparam logic [7:0] LP_TICKS =
        8'((LP_IDLE_MIN_MS + LP_IDLE_MAX_MS) / 2);
    localparam logic [7:0] LF_TICKS =
        8'((LF_LOSS_MIN_MS + LF_LOSS_MAX_MS) / 2);
    localparam logic [2:0] PULSES_TO_PASS = 3'h4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_STATUS = 8'h04;
    localparam int CTRL_LT_LSB = 0;
    localparam int CTRL_LP_LSB = 4;
    localparam int CTRL_PC_LSB = 8;
    localparam int CTRL_XD_LSB = 12;
    localparam int CTRL_TPALG_BIT = 16;
    localparam int CTRL_AUIALG_BIT = 17;
    localparam int ST_FAIL_LSB = 0;
    localparam int ST_INV_LSB = 4;
    localparam int ST_DONE_LSB = 8;
    localparam int ST_STRAP_LSB = 16;
    localparam logic [NPORT-1:0] LT_RESET = 4'hF;
    localparam logic [NPORT-1:0] LP_RESET = 4'hF;
    localparam logic [NPORT-1:0] XD_RESET = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] expansionSelectIn;
        logic serialIn;
        logic expansionCarrierIn;
        logic serialInDelayed;
        logic auiModeStrap;
    } rlp_strap_t;
    localparam int STRAP_W = $bits(rlp_strap_t);
    localparam rlp_strap_t STRAP_RESET = '0;

    typedef struct packed {
        logic [NPORT-1:0] linkPulse;
        logic [NPORT-1:0] packet;
        logic [NPORT-1:0] negDelim;
        logic [NPORT-1:0] posDelim;
    } rlp_rx_ev_t;

    typedef enum logic [1:0] {
        LINK_FAIL = 2'b01,
        LINK_PASS = 2'b10
    } rlp_link_t;

endpackage : rlp_pkg

//--- src/rlp_top.sv
// Reset, strap capture, link test and polarity correction for four TP ports
//
// How it works
// - Internal reset holds while the active-low reset pin is low.
// - All control and status registers return to defaults under reset.
// - Under reset outputs are inactive, nothing driven, transmitters idle.
// - Strap pins are sampled when reset is released.
// - AUI mode strap low gives normal mode, high gives reverse.
// - Both reconnection algorithm selects default to standard after reset.
// - Link test enabled on all ports, ports start in link fail.
// - Polarity correction defaults off if serial input strap high.
// - Link pulse sent after transmitter idle within 8 to 17 ms.
// - No packets or pulses for 65 to 132 ms gives link fail.
// - Link fail blocks rx/tx; four pulses or a packet exits it.
// - With link test disabled a port never enters link fail.
// - Link pulses go out whatever fail state, if the port's pulse transmission is enabled.
// - Per-port control enables or disables link pulse transmission.
// - Per-port extended-distance bit selects a reduced rx threshold.
// - Enabled correction inverts rx polarity on a negative delimiter.
// - Polarity detection runs once after reset or link-fail exit.
// - Polarity correction enable is a per-port control bit.
`timescale 1ns/1ps
`default_nettype none

module rlp_top
    import rlp_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_NOM
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Device reset pin and straps
    input wire logic resetPin_n,
    input wire rlp_strap_t strapPins,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [DW-1:0] pwdata,
    output logic pready,
    output logic [DW-1:0] prdata,
    output logic pslverr,
    // Twisted-pair receive events and transmit activity
    input wire rlp_rx_ev_t rxEvents,
    input wire logic [NPORT-1:0] txActive,
    // Port controls
    output logic [NPORT-1:0] linkPulseTx,
    output logic [NPORT-1:0] portRxEn,
    output logic [NPORT-1:0] portTxEn,
    output logic [NPORT-1:0] rxPolInvert,
    output logic [NPORT-1:0] rxThreshLow,
    // Repeater configuration
    output logic tpAlgAlt,
    output logic auiAlgAlt,
    output logic auiCiOutEn,
    output rlp_strap_t strapLatched,
    output logic inReset
);

    // ------------------------------------------------------------
    // Reset pin and strap synchronisers
    // ------------------------------------------------------------
    logic [STRAP_W:0] syncA;
    logic [STRAP_W:0] syncB;
    logic [STRAP_W:0] syncC;
    logic [STRAP_W:0] syncVal;
    logic rstInt;
    logic rstIntPrev;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            syncVal <= '0;
        end else begin
            syncA <= {resetPin_n, strapPins};
            syncB <= syncA;
            syncC <= syncB;
            for (int i = 0; i <= STRAP_W; i++) begin
                if (syncB[i] == syncC[i]) begin
                    syncVal[i] <= syncC[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        rstInt <= sys_rst | ~syncVal[STRAP_W];
        rstIntPrev <= rstInt;
    end

    always_ff @(posedge clk_sys) begin
        inReset <= rstInt;
    end

    logic releaseNow;
    rlp_strap_t syncStrap;
    assign releaseNow = rstIntPrev & ~rstInt;
    assign syncStrap = syncVal[STRAP_W-1:0];

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            strapLatched <= STRAP_RESET;
        end else if (releaseNow) begin
            strapLatched <= syncStrap;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            auiCiOutEn <= 1'b0;
        end else begin
            auiCiOutEn <= strapLatched.auiModeStrap;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [NPORT-1:0] linkTestEn;
    logic [NPORT-1:0] pulseTxEn;
    logic [NPORT-1:0] polCorrEn;
    logic [NPORT-1:0] extDist;
    logic [NPORT-1:0] linkFail;
    logic [NPORT-1:0] polDone;
    logic [NPORT-1:0] polInv;
    logic apbWrite;
    logic apbRead;
    logic hitCtrl;
    logic hitStatus;

    assign apbWrite = psel & penable & pwrite & ~pready;
    assign apbRead = psel & penable & ~pwrite & ~pready;
    assign hitCtrl = paddr == OFS_CTRL;
    assign hitStatus = paddr == OFS_STATUS;

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            linkTestEn <= LT_RESET;
        end else if (apbWrite && hitCtrl) begin
            linkTestEn <= pwdata[CTRL_LT_LSB +: NPORT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            pulseTxEn <= LP_RESET;
        end else if (apbWrite && hitCtrl) begin
            pulseTxEn <= pwdata[CTRL_LP_LSB +: NPORT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            extDist <= XD_RESET;
        end else if (apbWrite && hitCtrl) begin
            extDist <= pwdata[CTRL_XD_LSB +: NPORT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            tpAlgAlt <= 1'b0;
            auiAlgAlt <= 1'b0;
        end else if (apbWrite && hitCtrl) begin
            tpAlgAlt <= pwdata[CTRL_TPALG_BIT];
            auiAlgAlt <= pwdata[CTRL_AUIALG_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            polCorrEn <= '0;
        end else if (releaseNow) begin
            polCorrEn <= {NPORT{~syncStrap.serialIn}};
        end else if (apbWrite && hitCtrl) begin
            polCorrEn <= pwdata[CTRL_PC_LSB +: NPORT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            rxThreshLow <= '0;
        end else begin
            rxThreshLow <= extDist;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= (apbWrite & ~hitCtrl) |
                       (apbRead & ~hitCtrl & ~hitStatus);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            prdata <= '0;
        end else begin
            prdata <= '0;
            if (apbRead && hitCtrl) begin
                prdata[CTRL_LT_LSB +: NPORT] <= linkTestEn;
                prdata[CTRL_LP_LSB +: NPORT] <= pulseTxEn;
                prdata[CTRL_PC_LSB +: NPORT] <= polCorrEn;
                prdata[CTRL_XD_LSB +: NPORT] <= extDist;
                prdata[CTRL_TPALG_BIT] <= tpAlgAlt;
                prdata[CTRL_AUIALG_BIT] <= auiAlgAlt;
            end else if (apbRead && hitStatus) begin
                prdata[ST_FAIL_LSB +: NPORT] <= linkFail;
                prdata[ST_INV_LSB +: NPORT] <= polInv;
                prdata[ST_DONE_LSB +: NPORT] <= polDone;
                prdata[ST_STRAP_LSB +: STRAP_W] <= strapLatched;
            end
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [31:0] divCount;
    logic msTick;

    always_ff @(posedge clk_sys) begin
        if (rstInt) begin
            divCount <= '0;
            msTick <= 1'b0;
        end else if (divCount == 32'(MS_CYCLES - 1)) begin
            divCount <= '0;
            msTick <= 1'b1;
        end else begin
            divCount <= divCount + 32'h0000_0001;
            msTick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Per-port link test and polarity
    // ------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : gPort
        rlp_link_t linkState;
        rlp_link_t next_linkState;
        logic [7:0] idleTicks;
        logic [7:0] lossTicks;
        logic [2:0] pulseCount;
        logic heard;

        assign heard = rxEvents.linkPulse[p] | rxEvents.packet[p];

        // Transmit idle timer and link pulse generator
        always_ff @(posedge clk_sys) begin
            if (rstInt) begin
                idleTicks <= '0;
                linkPulseTx[p] <= 1'b0;
            end else if (txActive[p]) begin
                idleTicks <= '0;
                linkPulseTx[p] <= 1'b0;
            end else if (msTick && idleTicks == LP_TICKS - 8'h01) begin
                idleTicks <= '0;
                linkPulseTx[p] <= pulseTxEn[p];
            end else begin
                if (msTick) begin
                    idleTicks <= idleTicks + 8'h01;
                end
                linkPulseTx[p] <= 1'b0;
            end
        end

        // Receive silence timer
        always_ff @(posedge clk_sys) begin
            if (rstInt || heard) begin
                lossTicks <= '0;
            end else if (msTick && lossTicks != LF_TICKS) begin
                lossTicks <= lossTicks + 8'h01;
            end
        end

        // Consecutive link pulse counter
        always_ff @(posedge clk_sys) begin
            if (rstInt || linkState == LINK_PASS ||
                (lossTicks == LF_TICKS && !heard)) begin
                pulseCount <= '0;
            end else if (rxEvents.linkPulse[p] &&
                         pulseCount != PULSES_TO_PASS) begin
                pulseCount <= pulseCount + 3'h1;
            end
        end

        always_comb begin
            next_linkState = linkState;
            unique case (linkState)
                LINK_FAIL: begin
                    if (!linkTestEn[p] || rxEvents.packet[p] ||
                        (rxEvents.linkPulse[p] &&
                         pulseCount == PULSES_TO_PASS - 3'h1)) begin
                        next_linkState = LINK_PASS;
                    end
                end
                LINK_PASS: begin
                    if (linkTestEn[p] && lossTicks == LF_TICKS && !heard) begin
                        next_linkState = LINK_FAIL;
                    end
                end
                default: next_linkState = LINK_FAIL;
            endcase
        end

        always_ff @(posedge clk_sys) begin
            if (rstInt) begin
                linkState <= LINK_FAIL;
                linkFail[p] <= 1'b1;
                portRxEn[p] <= 1'b0;
                portTxEn[p] <= 1'b0;
            end else begin
                linkState <= next_linkState;
                linkFail[p] <= next_linkState == LINK_FAIL;
                portRxEn[p] <= next_linkState == LINK_PASS;
                portTxEn[p] <= next_linkState == LINK_PASS;
            end
        end

        // One-shot polarity decision, re-armed on each link-fail exit
        always_ff @(posedge clk_sys) begin
            if (rstInt) begin
                polDone[p] <= 1'b0;
                polInv[p] <= 1'b0;
            end else if (linkState == LINK_FAIL &&
                         next_linkState == LINK_PASS) begin
                polDone[p] <= 1'b0;
                polInv[p] <= 1'b0;
            end else if (linkState == LINK_PASS && !polDone[p] &&
                         polCorrEn[p]) begin
                if (rxEvents.negDelim[p]) begin
                    polInv[p] <= 1'b1;
                    polDone[p] <= 1'b1;
                end else if (rxEvents.posDelim[p]) begin
                    polDone[p] <= 1'b1;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rstInt) begin
                rxPolInvert[p] <= 1'b0;
            end else begin
                rxPolInvert[p] <= polInv[p] & polCorrEn[p];
            end
        end
    end

endmodule : rlp_top

`default_nettype wire

//--- tb/rlp_top_assertions.sv
// Checker for the reset, link and polarity block
`timescale 1ns/1ps
`default_nettype none

module rlp_top_checker
    import rlp_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_NOM
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Observed ports
    input wire logic pready,
    input wire rlp_rx_ev_t rxEvents,
    input wire logic [NPORT-1:0] txActive,
    input wire logic [NPORT-1:0] linkPulseTx,
    input wire logic [NPORT-1:0] portRxEn,
    input wire logic [NPORT-1:0] rxPolInvert,
    input wire logic auiCiOutEn,
    input wire rlp_strap_t strapLatched,
    input wire logic inReset
);
    localparam int PULSE_MIN = (int'(LP_TICKS) - 2) * MS_CYCLES;
    localparam int FAIL_MIN = (int'(LF_TICKS) - 2) * MS_CYCLES;
    logic [31:0] idleCnt;
    logic [31:0] quietCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Port 0 idle and silence counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst || inReset || txActive[0] || linkPulseTx[0]) begin
            idleCnt <= 32'h0000_0000;
        end else begin
            idleCnt <= idleCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || inReset || rxEvents.linkPulse[0]
                || rxEvents.packet[0]) begin
            quietCnt <= 32'h0000_0000;
        end else begin
            quietCnt <= quietCnt + 32'h0000_0001;
        end
    end

    quiet_in_reset_a: assert property (
        inReset && $past(inReset) |->
        {linkPulseTx, portRxEn, rxPolInvert, auiCiOutEn, pready,
         strapLatched} == 0)
        else $error("outputs active in reset");
    strap_hold_a: assert property (
        !inReset && !$past(inReset) && !$past(inReset, 2)
        |-> $stable(strapLatched)) else $error("straps moved");
    aui_mode_a: assert property (
        !inReset && !$past(inReset) && !$past(inReset, 2)
        |-> auiCiOutEn == strapLatched.auiModeStrap)
        else $error("aui mode wrong");
    packet_pass_a: assert property (
        !inReset && |rxEvents.packet |=> inReset ||
        (portRxEn & $past(rxEvents.packet)) == $past(rxEvents.packet))
        else $error("packet did not pass link");
    fail_entry_a: assert property (
        !inReset && $fell(portRxEn[0]) |-> quietCnt >= FAIL_MIN)
        else $error("link fail too early");
    pulse_gap_a: assert property (
        !inReset && linkPulseTx[0] |-> idleCnt >= PULSE_MIN)
        else $error("link pulse too early");
    pol_rise_a: assert property (
        $rose(rxPolInvert[0]) |-> $past(rxEvents.negDelim[0], 2))
        else $error("invert without delimiter");
    pol_hold_a: assert property (
        $fell(rxPolInvert[0]) |->
        inReset || !$past(portRxEn[0], 2))
        else $error("polarity decision dropped");
endmodule : rlp_top_checker

bind rlp_top rlp_top_checker #(.MS_CYCLES(MS_CYCLES)) chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pready(pready),
    .rxEvents(rxEvents), .txActive(txActive),
    .linkPulseTx(linkPulseTx), .portRxEn(portRxEn),
    .rxPolInvert(rxPolInvert), .auiCiOutEn(auiCiOutEn),
    .strapLatched(strapLatched), .inReset(inReset)
);

`default_nettype wire

//--- tb/rlp_link_partner.sv
// Link partner model sending pulses, packets and delimiters
`timescale 1ns/1ps
`default_nettype none

module rlp_link_partner
    import rlp_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Receive events towards the ports
    output rlp_rx_ev_t rxEvents
);
    initial begin
        rxEvents = '0;
    end

    // Kind 0 pos delimiter, 1 neg delimiter, 2 packet, 3 link pulse
    task automatic send(input int kind, input int port, input int n,
                        input int gap);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_sys);
            rxEvents <= rlp_rx_ev_t'(16'h0001 << (kind * 4 + port));
            @(posedge clk_sys);
            rxEvents <= '0;
            repeat (gap) @(posedge clk_sys);
        end
    endtask : send
endmodule : rlp_link_partner

`default_nettype wire

//--- tb/rlp_top_bench.sv
// Self-checking bench for the reset, link and polarity block
`timescale 1ns/1ps
`default_nettype none

module rlp_top_bench
    import rlp_pkg::*;
();
    localparam int MSC = 8;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic resetPin_n = 1'b0;
    rlp_strap_t strapPins = 6'h25;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = 8'h00;
    logic [DW-1:0] pwdata = 32'h0000_0000;
    logic [NPORT-1:0] txActive = 4'h0;
    logic pready, pslverr, tpAlgAlt, auiAlgAlt, auiCiOutEn, inReset;
    logic [DW-1:0] prdata;
    rlp_rx_ev_t rxEvents;
    rlp_strap_t strapLatched;
    logic [NPORT-1:0] linkPulseTx, portRxEn, portTxEn, rxPolInvert;
    logic [NPORT-1:0] rxThreshLow;
    logic [DW-1:0] rd;
    logic err;
    int fails = 0;
    int checks = 0;

    always #2 clk_sys = ~clk_sys;

    rlp_top #(.MS_CYCLES(MSC)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .resetPin_n(resetPin_n), .strapPins(strapPins), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .rxEvents(rxEvents), .txActive(txActive),
        .linkPulseTx(linkPulseTx), .portRxEn(portRxEn),
        .portTxEn(portTxEn), .rxPolInvert(rxPolInvert),
        .rxThreshLow(rxThreshLow), .tpAlgAlt(tpAlgAlt),
        .auiAlgAlt(auiAlgAlt), .auiCiOutEn(auiCiOutEn),
        .strapLatched(strapLatched), .inReset(inReset));
    rlp_link_partner partner (.clk_sys(clk_sys), .rxEvents(rxEvents));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [AW-1:0] a,
                       input logic [DW-1:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [AW-1:0] a,
                         input logic [DW-1:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rd, exp);
    endtask : rdchk

    task automatic settle();
        int n;
        n = 0;
        while (inReset !== 1'b0 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        check("released", inReset, 1'b0);
    endtask : settle

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rdchk("ctrl", OFS_CTRL, 32'h0000_0FFF);
        rdchk("status", OFS_STATUS, 32'h0025_000F);
        @(negedge clk_sys);
        check("aui", auiCiOutEn, 1'b1);
        check("algs", {tpAlgAlt, auiAlgAlt, portRxEn}, 6'h00);
        @(posedge clk_sys);
        strapPins <= 6'h1A;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        check("straps", strapLatched, 6'h25);
    endtask : t_defaults

    task automatic t_link();
        partner.send(3, 0, 3, 20);
        @(negedge clk_sys);
        check("three pulses", portRxEn[0], 1'b0);
        partner.send(3, 0, 1, 2);
        partner.send(2, 1, 1, 2);
        @(negedge clk_sys);
        check("rx tx", {portRxEn, portTxEn}, 8'h33);
        partner.send(1, 0, 1, 2);
        partner.send(0, 1, 1, 2);
        partner.send(1, 1, 1, 2);
        apb(1'b1, OFS_CTRL, 32'h0000_0BFF);
        partner.send(2, 2, 1, 2);
        partner.send(1, 2, 1, 2);
        @(negedge clk_sys);
        check("invert", rxPolInvert, 4'h1);
    endtask : t_link

    task automatic t_fail();
        apb(1'b1, OFS_CTRL, 32'h0000_0BF7);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("lt off", portRxEn, 4'hF);
        repeat (85 * MSC) @(posedge clk_sys);
        @(negedge clk_sys);
        check("held", portRxEn, 4'hF);
        repeat (20 * MSC) @(posedge clk_sys);
        @(negedge clk_sys);
        check("fail", {portRxEn, portTxEn}, 8'h88);
    endtask : t_fail

    task automatic t_pulse();
        int cnt [NPORT];
        int first;
        int gap;
        cnt = '{default: 0};
        first = 0;
        gap = 0;
        @(posedge clk_sys);
        txActive <= 4'h2;
        apb(1'b1, OFS_CTRL, 32'h0000_0B7F);
        for (int c = 0; c < 250; c++) begin
            @(negedge clk_sys);
            for (int p = 0; p < NPORT; p++) begin
                if (linkPulseTx[p] === 1'b1) cnt[p]++;
            end
            if (linkPulseTx[0] === 1'b1 && cnt[0] == 1) first = c;
            if (linkPulseTx[0] === 1'b1 && cnt[0] == 2) gap = c - first;
        end
        check("gap", gap >= 88 && gap <= 104, 1'b1);
        check("busy port", cnt[1], 0);
        check("fail port", cnt[2] > 0, 1'b1);
        check("off port", cnt[3], 0);
        @(posedge clk_sys);
        txActive <= 4'h0;
    endtask : t_pulse

    task automatic t_apb();
        apb(1'b1, OFS_CTRL, 32'h0003_5B7F);
        rdchk("ctrl rw", OFS_CTRL, 32'h0003_5B7F);
        @(negedge clk_sys);
        check("thresh", {rxThreshLow, tpAlgAlt, auiAlgAlt}, 6'h17);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
        apb(1'b1, OFS_STATUS, 32'h0000_0000);
        check("ro status", err, 1'b1);
    endtask : t_apb

    task automatic t_rereset();
        @(posedge clk_sys);
        strapPins <= 6'h08;
        resetPin_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        check("in reset", inReset, 1'b1);
        check("quiet", {portRxEn, rxPolInvert, rxThreshLow, tpAlgAlt,
            auiAlgAlt, auiCiOutEn, pready}, 16'h0000);
        repeat (980) @(posedge clk_sys);
        resetPin_n <= 1'b1;
        settle();
        rdchk("ctrl again", OFS_CTRL, 32'h0000_00FF);
        @(negedge clk_sys);
        check("aui normal", auiCiOutEn, 1'b0);
        check("straps again", strapLatched, 6'h08);
    endtask : t_rereset

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (37500) @(posedge clk_sys);
        resetPin_n <= 1'b1;
        settle();
        t_defaults();
        t_link();
        t_fail();
        t_pulse();
        t_apb();
        t_rereset();
        results();
    end

    initial begin
        #240000;
        fails++;
        results();
    end
endmodule : rlp_top_bench

`default_nettype wire
